// [twb_map.svh]
`ifndef TWB_MAP_SVH
`define TWB_MAP_SVH
`define TWB_CLK_NS 10
`define TWB_T_LOW_NS 4700
`define TWB_T_HIGH_NS 4000
`define TWB_LOW_CYC ((`TWB_T_LOW_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)
`define TWB_HIGH_CYC ((`TWB_T_HIGH_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)
`define TWB_LOW_LAST 10'(`TWB_LOW_CYC - 1)
`define TWB_HIGH_LAST 10'(`TWB_HIGH_CYC - 1)
`define TWB_LOW_HALF 10'(`TWB_LOW_CYC / 2)
`define TWB_ACK_IDX 4'h8
`define TWB_PIN_RST 2'h3
`endif

// [twb_pkg.sv]
package twb_pkg;
  typedef enum logic [1:0] {TWB_OP_START, TWB_OP_WRITE, TWB_OP_READ, TWB_OP_STOP} twb_op_type;
  typedef struct packed {
    twb_op_type op;
    logic ack;
    logic [7:0] data;
  } twb_cmd_type;
  typedef struct packed {
    logic [7:0] data;
    logic nack;
    logic arb_lost;
    logic refused;
  } twb_rsp_type;
  typedef struct packed {
    logic scl;
    logic sda;
  } twb_pin_type;
  typedef enum logic [3:0] {
    S_IDLE, S_START, S_HOLD, S_LOW, S_HIGH, S_RS_LOW, S_RS_HIGH, S_STOP_LOW, S_STOP_HIGH
  } twb_state_type;
endpackage

// [twb_sync.sv]
`timescale 1ns/10ps
`include "twb_map.svh"
module twb_sync (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire twb_pkg::twb_pin_type pin_raw,
  output twb_pkg::twb_pin_type pin_sync
);
  import twb_pkg::*;
  twb_pin_type stage;
  // Two flops per line, released lines idle high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage <= `TWB_PIN_RST;
      pin_sync <= `TWB_PIN_RST;
    end else begin
      stage <= pin_raw;
      pin_sync <= stage;
    end
  end
endmodule

// [twb_master.sv]
`timescale 1ns/10ps
`include "twb_map.svh"
// What this block does
// RL1 - First byte after a start is seven-bit address plus direction bit.
// RL2 - Direction bit one means read, zero means write.
// RL3 - Only the slave matching the address acknowledges in ninth clock.
// RL4 - Device master never calls its own slave address.
// RL5 - Device is never master and slave at once; falls back after loss.
// RL6 - Bytes are eight bits, one clock each, most significant first.
// RL7 - Data changes only while clock is low, stable while high.
// RL8 - Receiver drives ninth acknowledge bit low; nine clocks per byte.
// RL9 - Unacknowledged byte leaves data high; master treats transfer as failed.
// RL10 - Master receiver withholding acknowledge ends slave transmission.
// RL11 - After failed byte, master issues stop or repeated start.
// RL12 - Stop is data rising while clock is high.
// RL13 - Master may stop after an acknowledge; slave then releases bus.
// RL14 - Repeated start is allowed without stop, keeping the bus.
// RL15 - Master sending one but seeing zero loses and releases data.
// RL16 - Losing arbitration produces no stop condition.
// RL17 - Arbitration loss is flagged for software.
// RL18 - Shared clock low is longest low, high is shortest high.
// RL19 - Count own low time, then wait while clock stays low.
// RL20 - Count high once clock rises; first finisher pulls low.
// RL21 - Clock and data lines are both driven and sensed.
// RL22 - Start is data falling while clock is high, bus idle or restart.
// RL23 - Lines are only pulled low or released, never driven high.
module twb_master (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire twb_pkg::twb_cmd_type cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output twb_pkg::twb_rsp_type rsp,
  output logic bus_busy,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import twb_pkg::*;

  // ==========================================
  // Pin sampling and bus condition detection
  twb_pin_type pins;
  twb_pin_type pins_d;
  twb_sync u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_raw({scl_i, sda_i}),
    .pin_sync(pins)
  );
  wire scl_s = pins.scl;
  wire sda_s = pins.sda;
  wire bus_start = scl_s && pins_d.scl && pins_d.sda && !sda_s;
  wire bus_stop = scl_s && pins_d.scl && !pins_d.sda && sda_s;

  // ==========================================
  // State
  twb_state_type state;
  twb_state_type next_state;
  logic [9:0] cnt;
  logic [3:0] bit_idx;
  logic [7:0] shreg;
  logic rd;
  logic ack_q;
  logic addr_pend;
  logic dir;
  logic done_nack;
  logic hi_seen;
  logic next_sda_oe;

  // ==========================================
  // Decoding
  wire take = cmd_valid && cmd_ready;
  wire is_rd = cmd.op == TWB_OP_READ;
  wire is_wr = cmd.op == TWB_OP_WRITE;
  wire in_hold = state == S_HOLD;
  wire hi_state = state == S_HIGH || state == S_RS_HIGH || state == S_STOP_HIGH;
  wire low_state = state == S_LOW || state == S_RS_LOW || state == S_STOP_LOW;
  wire counting = low_state || state == S_START || (hi_state && hi_seen);
  wire low_done = cnt == `TWB_LOW_LAST;
  wire high_done = cnt == `TWB_HIGH_LAST;
  wire mid_low = cnt == `TWB_LOW_HALF;
  wire ack_bit = bit_idx == `TWB_ACK_IDX;
  // Pull-low value of the current bit and whether this end is the sender
  wire tx_pull = ack_bit ? (rd && ack_q) : (!rd && !shreg[7]); // see RL6
  wire sending = ack_bit ? rd : !rd;
  wire arb_now = state == S_HIGH && hi_seen && sending && !sda_oe && !sda_s; // see RL15
  wire hi_end = state == S_HIGH && hi_seen && (high_done || !scl_s); // see RL18 RL20
  wire bad_dir = (is_rd && (addr_pend || !dir)) || (is_wr && !addr_pend && dir); // see RL2
  wire refuse = take && (is_rd || is_wr) && (!in_hold || done_nack || bad_dir); // see RL11
  wire refuse_stop = take && cmd.op == TWB_OP_STOP && state == S_IDLE;
  // Host owns no slave address, so no call can hit its own
  wire byte_go = take && in_hold && (is_rd || is_wr) && !refuse; // see RL4

  // ==========================================
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (take && cmd.op == TWB_OP_START) next_state = S_START;
      S_START: if (high_done) next_state = S_HOLD; // see RL22
      S_HOLD: begin
        if (take && cmd.op == TWB_OP_START) next_state = S_RS_LOW; // see RL14
        else if (take && cmd.op == TWB_OP_STOP) next_state = S_STOP_LOW; // see RL13
        else if (byte_go) next_state = S_LOW;
      end
      S_LOW: if (low_done) next_state = S_HIGH;
      S_HIGH: begin
        if (arb_now) next_state = S_IDLE; // see RL5 RL16
        else if (hi_end) next_state = ack_bit ? S_HOLD : S_LOW; // see RL8
      end
      S_RS_LOW: if (low_done) next_state = S_RS_HIGH;
      S_RS_HIGH: if (hi_seen && high_done) next_state = S_START;
      S_STOP_LOW: if (low_done) next_state = S_STOP_HIGH;
      S_STOP_HIGH: if (hi_seen && high_done) next_state = S_IDLE;
    endcase
  end

  // Data line moves only at mid-low, or at start and stop edges
  always_comb begin
    next_sda_oe = sda_oe;
    unique case (state)
      S_IDLE: next_sda_oe = 1'b0;
      S_START: next_sda_oe = 1'b1; // see RL22
      S_LOW: if (mid_low) next_sda_oe = tx_pull; // see RL7
      S_RS_LOW: if (mid_low) next_sda_oe = 1'b0;
      S_STOP_LOW: if (mid_low) next_sda_oe = 1'b1;
      S_STOP_HIGH: if (next_state == S_IDLE) next_sda_oe = 1'b0; // see RL12
      S_HIGH: if (arb_now) next_sda_oe = 1'b0;
      default: next_sda_oe = sda_oe;
    endcase
  end

  // ==========================================
  // Pin drivers, timing and status
  always_ff @(posedge sys_clk) begin
    scl_o <= 1'b0; // see RL23
    sda_o <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      cnt <= 10'h000;
      hi_seen <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      pins_d <= `TWB_PIN_RST;
      bus_busy <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 10'h000 : (counting ? cnt + 10'h001 : cnt); // see RL19
      hi_seen <= (next_state == state) && hi_state && (hi_seen || scl_s); // see RL19
      scl_oe <= next_state inside {S_HOLD, S_LOW, S_RS_LOW, S_STOP_LOW}; // see RL21
      sda_oe <= next_sda_oe;
      pins_d <= pins;
      bus_busy <= bus_start || (bus_busy && !bus_stop);
      cmd_ready <= next_state == S_HOLD || (next_state == S_IDLE && !bus_busy);
    end
  end

  // ==========================================
  // Byte shifting and transfer bookkeeping
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bit_idx <= 4'h0;
      shreg <= 8'h00;
      rd <= 1'b0;
      ack_q <= 1'b0;
      addr_pend <= 1'b0;
      dir <= 1'b0;
      done_nack <= 1'b0;
    end else begin
      if (take && cmd.op == TWB_OP_START) begin
        addr_pend <= 1'b1; // see RL1
        done_nack <= 1'b0;
      end else if (take && cmd.op == TWB_OP_STOP) begin
        done_nack <= 1'b0;
      end
      if (byte_go) begin
        shreg <= cmd.data;
        rd <= is_rd;
        ack_q <= cmd.ack;
        bit_idx <= 4'h0;
        if (addr_pend) dir <= cmd.data[0]; // see RL1
      end else if (hi_end) begin
        bit_idx <= bit_idx + 4'h1;
        if (!ack_bit) shreg <= {shreg[6:0], sda_s}; // see RL6
        if (ack_bit) begin
          addr_pend <= 1'b0;
          done_nack <= rd ? !ack_q : sda_s; // see RL9 RL10
        end
      end
    end
  end

  // ==========================================
  // Answers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (refuse || refuse_stop) begin
        rsp_valid <= 1'b1;
        rsp <= '{data: 8'h00, nack: 1'b0, arb_lost: 1'b0, refused: 1'b1};
      end else if (arb_now) begin
        rsp_valid <= 1'b1;
        rsp <= '{data: shreg, nack: 1'b0, arb_lost: 1'b1, refused: 1'b0}; // see RL17
      end else if (hi_end && ack_bit) begin
        rsp_valid <= 1'b1;
        rsp <= '{data: shreg, nack: sda_s, arb_lost: 1'b0, refused: 1'b0}; // see RL3 RL9
      end else if ((state == S_START && high_done) ||
                   (state == S_STOP_HIGH && next_state == S_IDLE)) begin
        rsp_valid <= 1'b1;
        rsp <= '{data: 8'h00, nack: 1'b0, arb_lost: 1'b0, refused: 1'b0};
      end
    end
  end

  // ==========================================
  // Checks
  property p_sda_low_only;
    @(posedge sys_clk) disable iff (sys_rst)
    $changed(sda_oe) && !$past(arb_now) |->
      $past(scl_oe) || $past(state) inside {S_START, S_STOP_HIGH, S_IDLE};
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("data moved with clock high"); // see RL7

  property p_stop_edge;
    @(posedge sys_clk) disable iff (sys_rst)
    state == S_STOP_HIGH && next_state == S_IDLE |-> sda_oe && !scl_oe ##1 !sda_oe && !scl_oe;
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("stop not a data rise"); // see RL12

  property p_start_edge;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(sda_oe) && !scl_oe |-> state == S_START;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("data fell outside start"); // see RL22

  property p_arb_release;
    @(posedge sys_clk) disable iff (sys_rst)
    arb_now |=> !sda_oe && !scl_oe && state == S_IDLE && rsp_valid && rsp.arb_lost;
  endproperty
  a_arb_release: assert property (p_arb_release) else $error("arbitration loss mishandled"); // see RL15

  property p_arb_no_stop;
    @(posedge sys_clk) disable iff (sys_rst)
    arb_now |=> state != S_STOP_LOW ##1 state != S_STOP_HIGH;
  endproperty
  a_arb_no_stop: assert property (p_arb_no_stop) else $error("stop after arbitration loss"); // see RL16

  property p_low_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    state == S_LOW && !low_done |=> state == S_LOW && scl_oe;
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("clock low cut short"); // see RL19

  property p_never_high;
    @(posedge sys_clk) disable iff (sys_rst)
    scl_oe || sda_oe |-> !scl_o && !sda_o;
  endproperty
  a_never_high: assert property (p_never_high) else $error("line driven high"); // see RL23

  property p_ack_drive;
    @(posedge sys_clk) disable iff (sys_rst)
    state == S_LOW && ack_bit && mid_low |=> sda_oe == (rd && ack_q);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge bit wrong"); // see RL8

  property p_nine_bits;
    @(posedge sys_clk) disable iff (sys_rst)
    hi_end && !ack_bit |=> state == S_LOW && bit_idx == $past(bit_idx) + 4'h1;
  endproperty
  a_nine_bits: assert property (p_nine_bits) else $error("byte ended early"); // see RL6

  property p_failed_refuse;
    @(posedge sys_clk) disable iff (sys_rst)
    take && done_nack && (is_rd || is_wr) |=> rsp_valid && rsp.refused && state == S_HOLD;
  endproperty
  a_failed_refuse: assert property (p_failed_refuse) else $error("byte after failed transfer"); // see RL11
endmodule

// [twb_slave_model.sv]
`timescale 1ns/10ps
module twb_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2a,
  parameter logic [7:0] RD_BYTE = 8'h9c
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] got_byte
);
  logic [7:0] shift;
  logic [3:0] cnt;
  logic active, addr_ph, sel, rw, mack;
  // ========
  // Line handling
  initial begin
    scl_pull = 0;
    sda_pull = 0;
    got_byte = 0;
    active = 0;
    sel = 0;
    cnt = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    active = 1;
    addr_ph = 1;
    sel = 0;
  end
  // Stop frees the line
  always @(posedge sda) if (scl === 1'b1) begin
    active = 0;
    sel = 0;
    sda_pull = 0;
  end
  // Sample MSB first while clock high
  always @(posedge scl) if (active) begin
    if (cnt < 4'h8) shift = {shift[6:0], sda};
    else mack = !sda;
    cnt = cnt + 4'h1;
  end
  // Drive only while clock low
  always @(negedge scl) if (active) begin
    if (cnt == 4'h8) begin
      got_byte = shift;
      if (addr_ph) begin
        sel = (shift[7:1] == OWN_ADDR);
        rw = shift[0];
      end
      sda_pull = sel && (addr_ph || !rw);
      if (stretch) begin
        scl_pull = 1;
        #8000 scl_pull = 0;
      end
    end else if (cnt == 4'h9) begin
      cnt = 0;
      if (sel && rw && !addr_ph && !mack) sel = 0;
      addr_ph = 0;
      sda_pull = sel && rw && !RD_BYTE[7];
    end else begin
      sda_pull = sel && rw && !addr_ph && !RD_BYTE[3'(7 - cnt)];
    end
  end
endmodule

// [twb_master_tb.sv]
`timescale 1ns/10ps
module twb_master_tb;
  import twb_pkg::*;
  localparam logic [6:0] SLV = 7'h2a;
  localparam logic [7:0] RDB = 8'h9c;
  logic sys_clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, bus_busy;
  logic scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda, t_sda, stretch;
  logic [7:0] slv_byte;
  twb_cmd_type cmd;
  twb_rsp_type rsp, got;
  int err_total, num_checks, cyc, n_start, n_stop, s0, p0;
  wire logic scl = ~(scl_oe | s_scl);
  wire logic sda = ~(sda_oe | s_sda | t_sda);
  twb_master i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .bus_busy(bus_busy),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  twb_slave_model #(.OWN_ADDR(SLV), .RD_BYTE(RDB)) i_slave (.scl(scl), .sda(sda),
    .stretch(stretch), .scl_pull(s_scl), .sda_pull(s_sda), .got_byte(slv_byte));
  // ========
  // Clock, monitors, timeout
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sda) if (scl === 1'b1 && !sys_rst) n_start++;
  always @(posedge sda) if (scl === 1'b1 && !sys_rst) n_stop++;
  always @(posedge sys_clk) begin
    if (!sys_rst && (scl_o | sda_o) !== 1'b0) check("drive_high", 11'h1, 11'h0);
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      summarize();
    end
  end
  // ========
  // Shared tasks
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic do_cmd(input twb_op_type op, input logic ak, input logic [7:0] d,
      input logic arb);
    int n;
    // Idle edge keeps strobes of back-to-back calls apart
    wait_clk(1);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      wait_clk(1);
      n++;
    end
    cmd_valid = 1;
    cmd = '{op: op, ack: ak, data: d};
    wait_clk(1);
    cmd_valid = 0;
    if (arb) begin
      wait_clk(300);
      t_sda = 1;
    end
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      wait_clk(1);
      n++;
    end
    check("rsp_valid", 11'(rsp_valid), 11'h1);
    got = rsp;
  endtask
  // ========
  // Scenarios
  task automatic sc_write();
    do_cmd(TWB_OP_WRITE, 0, 8'h3c, 0);
    check("idle_refused", 11'(got.refused), 11'h1);
    do_cmd(TWB_OP_STOP, 0, 8'h00, 0);
    check("stop_refused", 11'(got.refused), 11'h1);
    s0 = n_start;
    do_cmd(TWB_OP_START, 0, 8'h00, 0);
    check("start_seen", 11'(n_start), 11'(s0 + 1));
    stretch = 1;
    do_cmd(TWB_OP_WRITE, 0, {SLV, 1'b0}, 0);
    stretch = 0;
    check("addr_nack", 11'(got.nack), 11'h0);
    check("addr_byte", 11'(slv_byte), 11'({SLV, 1'b0}));
    do_cmd(TWB_OP_WRITE, 0, 8'ha5, 0);
    check("wr_nack", 11'(got.nack), 11'h0);
    check("wr_byte", 11'(slv_byte), 11'h0a5);
    check("wr_rsp", 11'(got.data), 11'h0a5);
    p0 = n_stop;
    do_cmd(TWB_OP_STOP, 0, 8'h00, 0);
    check("stop_seen", 11'(n_stop), 11'(p0 + 1));
    wait_clk(5);
    check("busy_free", {10'h0, bus_busy}, 11'h0);
    check("ready_free", 11'(cmd_ready), 11'h1);
  endtask
  task automatic sc_nack();
    do_cmd(TWB_OP_START, 0, 8'h00, 0);
    do_cmd(TWB_OP_READ, 1, 8'h00, 0);
    check("rd_first", 11'(got.refused), 11'h1);
    do_cmd(TWB_OP_WRITE, 0, {7'h11, 1'b0}, 0);
    check("miss_nack", 11'(got.nack), 11'h1);
    do_cmd(TWB_OP_WRITE, 0, 8'h00, 0);
    check("after_nack", 11'(got.refused), 11'h1);
    p0 = n_stop;
    do_cmd(TWB_OP_STOP, 0, 8'h00, 0);
    check("nack_stop", 11'(n_stop), 11'(p0 + 1));
  endtask
  task automatic sc_read();
    do_cmd(TWB_OP_START, 0, 8'h00, 0);
    do_cmd(TWB_OP_WRITE, 0, {SLV, 1'b0}, 0);
    p0 = n_stop;
    s0 = n_start;
    do_cmd(TWB_OP_START, 0, 8'h00, 0);
    check("rs_nostop", 11'(n_stop), 11'(p0));
    check("rs_start", 11'(n_start), 11'(s0 + 1));
    do_cmd(TWB_OP_WRITE, 0, {SLV, 1'b1}, 0);
    check("rd_addr", 11'(got.nack), 11'h0);
    do_cmd(TWB_OP_WRITE, 0, 8'h00, 0);
    check("wr_in_read", 11'(got.refused), 11'h1);
    do_cmd(TWB_OP_READ, 1, 8'h00, 0);
    check("rd_data", {got.data, got.nack, 2'h0}, {RDB, 3'h0});
    do_cmd(TWB_OP_READ, 0, 8'h00, 0);
    check("rd_last", {got.data, got.nack, 2'h0}, {RDB, 3'h4});
    check("slv_free", 11'(s_sda), 11'h0);
    do_cmd(TWB_OP_READ, 1, 8'h00, 0);
    check("rd_refused", 11'(got.refused), 11'h1);
    do_cmd(TWB_OP_STOP, 0, 8'h00, 0);
  endtask
  task automatic sc_arb();
    do_cmd(TWB_OP_START, 0, 8'h00, 0);
    p0 = n_stop;
    do_cmd(TWB_OP_WRITE, 0, 8'h80, 1);
    check("arb_flag", 11'(got.arb_lost), 11'h1);
    wait_clk(50);
    check("arb_release", 11'({scl_oe, sda_oe}), 11'h0);
    check("arb_nostop", 11'(n_stop), 11'(p0));
    check("arb_busy", {10'h0, bus_busy}, 11'h1);
    check("arb_wait", 11'(cmd_ready), 11'h0);
    t_sda = 0;
    wait_clk(50);
    check("arb_free", {10'h0, bus_busy}, 11'h0);
  endtask
  // ========
  // Main sequence
  initial begin
    sys_rst = 1;
    cmd_valid = 0;
    cmd = '0;
    t_sda = 0;
    stretch = 0;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    n_start = 0;
    n_stop = 0;
    wait_clk(5);
    sys_rst = 0;
    wait_clk(2);
    sc_write();
    sc_nack();
    sc_read();
    sc_arb();
    summarize();
  end
endmodule
